// file: rtl/ppm_pkg.sv
// Purpose: constants for the power-management capability register
// Assumes: 32-bit configuration dword reads, one dword per access
// Notes:   all fields are hardwired or strapped; nothing here resets
package ppm_pkg;
   // ****************************************
   // register address and field positions
   // ****************************************
   localparam logic [7:0] PPM_CAP_OFFSET      = 8'h40; // byte offset of the dword in config space
   localparam int         PPM_WAKE_LSB        = 27;    // wake source field 31..27
   localparam int         PPM_D2_BIT          = 26;
   localparam int         PPM_D1_BIT          = 25;
   localparam int         PPM_AUX_LSB         = 22;    // aux current field 24..22
   localparam int         PPM_DSI_BIT         = 21;
   localparam int         PPM_RSVD_BIT        = 20;
   localparam int         PPM_CLK_BIT         = 19;
   localparam int         PPM_VER_LSB         = 16;    // version field 18..16
   localparam int         PPM_NEXT_LSB        = 8;     // next pointer 15..8
   localparam int         PPM_ID_LSB          = 0;     // capability id 7..0
   // ****************************************
   // field values
   // ****************************************
   localparam logic [4:0] PPM_WAKE_WITH_AUX   = 5'h1f; // d0..d3cold
   localparam logic [4:0] PPM_WAKE_NO_AUX     = 5'h0f; // d0..d3hot
   localparam logic       PPM_D2_SUPPORT      = 1'h1;
   localparam logic       PPM_D1_SUPPORT      = 1'h1;
   localparam logic       PPM_DSI_VALUE       = 1'h0;
   localparam logic       PPM_RSVD_VALUE      = 1'h0;
   localparam logic       PPM_CLK_VALUE       = 1'h0;
   localparam logic [2:0] PPM_VER_10A         = 3'h2;  // revision 1.0a
   localparam logic [2:0] PPM_VER_10          = 3'h1;  // revision 1.0
   localparam logic [2:0] PPM_AUX_10_VALUE    = 3'h0;  // reserved in 1.0 layout
   localparam logic [7:0] PPM_NEXT_VALUE      = 8'h00;
   localparam logic [7:0] PPM_ID_VALUE        = 8'h01;
   localparam logic [31:0] PPM_ZERO           = 32'h0000_0000;
endpackage

// file: rtl/ppm_field_pack.sv
// Purpose: packs the capability fields into one 32-bit dword
// Assumes: inputs are static straps
// Notes:   pure combinational
`timescale 1ns/100ps
module ppm_field_pack
(
   input  wire logic        aux_present,             // aux supply detected
   input  wire logic        autoload_en,             // 1.0a layout select
   input  wire logic [2:0]  aux_current_requirement, // strapped aux current
   output logic      [31:0] power_mgmt_capabilities  // assembled dword
);
   // ****************************************
   // field assembly
   // ****************************************
   always_comb
   begin
      power_mgmt_capabilities = ppm_pkg::PPM_ZERO;
      // wake source depends on aux supply
      if (aux_present)
      begin
         power_mgmt_capabilities[ppm_pkg::PPM_WAKE_LSB +: 5] = ppm_pkg::PPM_WAKE_WITH_AUX;
      end
      else
      begin
         power_mgmt_capabilities[ppm_pkg::PPM_WAKE_LSB +: 5] = ppm_pkg::PPM_WAKE_NO_AUX;
      end
      power_mgmt_capabilities[ppm_pkg::PPM_D2_BIT] = ppm_pkg::PPM_D2_SUPPORT;
      power_mgmt_capabilities[ppm_pkg::PPM_D1_BIT] = ppm_pkg::PPM_D1_SUPPORT;
      // layout select: aux field and version differ
      if (autoload_en)
      begin
         power_mgmt_capabilities[ppm_pkg::PPM_AUX_LSB +: 3] = aux_current_requirement;
         power_mgmt_capabilities[ppm_pkg::PPM_VER_LSB +: 3] = ppm_pkg::PPM_VER_10A;
      end
      else
      begin
         power_mgmt_capabilities[ppm_pkg::PPM_AUX_LSB +: 3] = ppm_pkg::PPM_AUX_10_VALUE;
         power_mgmt_capabilities[ppm_pkg::PPM_VER_LSB +: 3] = ppm_pkg::PPM_VER_10;
      end
      power_mgmt_capabilities[ppm_pkg::PPM_DSI_BIT]  = ppm_pkg::PPM_DSI_VALUE;
      power_mgmt_capabilities[ppm_pkg::PPM_RSVD_BIT] = ppm_pkg::PPM_RSVD_VALUE;
      power_mgmt_capabilities[ppm_pkg::PPM_CLK_BIT]  = ppm_pkg::PPM_CLK_VALUE;
      power_mgmt_capabilities[ppm_pkg::PPM_NEXT_LSB +: 8] = ppm_pkg::PPM_NEXT_VALUE;
      power_mgmt_capabilities[ppm_pkg::PPM_ID_LSB +: 8]   = ppm_pkg::PPM_ID_VALUE;
   end
endmodule

// file: rtl/ppm_cap_regs.sv
// Purpose: power-management capability dword on the configuration read port
// Assumes: cfg_rd / cfg_wr are one-cycle strobes synchronous to core_clk
// Notes:   read data appears one cycle after the strobe; writes are dropped
`timescale 1ns/100ps
module ppm_cap_regs
(
   input  wire logic        core_clk,                // 10 mhz clock
   input  wire logic        srst,                    // sync reset, active high
   input  wire logic        cfg_rd,                  // config read strobe
   input  wire logic        cfg_wr,                  // config write strobe
   input  wire logic [7:0]  cfg_addr,                // dword-aligned byte offset
   input  wire logic [31:0] cfg_wdata,               // write data, unused
   input  wire logic        aux_present,             // aux supply present
   input  wire logic        autoload_en,             // auto-load enabled
   input  wire logic [2:0]  aux_current_requirement, // strapped aux current
   output logic      [31:0] cfg_rdata,               // read data
   output logic             cfg_rvalid,              // read data valid pulse
   output logic             cfg_hit                  // address hits register
);
   // ****************************************
   // field assembly
   // ****************************************
   // the dword is rebuilt every cycle from the straps; nothing here is
   // stored, so hard and soft resets cannot disturb the reported value
   logic [31:0] cap_word; // live capability value

   ppm_field_pack u_pack
   (
      .aux_present             (aux_present),
      .autoload_en             (autoload_en),
      .aux_current_requirement (aux_current_requirement),
      .power_mgmt_capabilities (cap_word)
   );

   // ****************************************
   // address decode
   // ****************************************
   // only one dword lives in this window; any other offset is a miss
   // a plain compare, so cfg_hit is valid in the strobe cycle itself
   assign cfg_hit = (cfg_addr == ppm_pkg::PPM_CAP_OFFSET);

   // ****************************************
   // read data select
   // ****************************************
   logic [31:0] next_rdata; // value loaded by the next read strobe

   // hit returns the live dword, a miss returns zero
   // the select is pure logic; only the two registers below hold state
   always_comb
   begin
      if (cfg_hit)
      begin
         // straps are taken at the strobe edge, so a strap that moves
         // between reads shows up on the next read only
         next_rdata = cap_word;
      end
      else
      begin
         // unmapped offsets read as zero rather than floating
         next_rdata = ppm_pkg::PPM_ZERO;
      end
   end

   // ****************************************
   // read valid pulse
   // ****************************************
   // one pulse per strobe, exactly one cycle after it; back-to-back
   // strobes give back-to-back pulses with no gap
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         cfg_rvalid <= 1'b0; // nothing pending after reset
      end
      else
      begin
         cfg_rvalid <= cfg_rd; // answer follows the strobe by one edge
      end
   end

   // ****************************************
   // read data register; writes never touch it
   // ****************************************
   // only a read strobe or srst loads this register, and cfg_wr and cfg_wdata
   // feed nothing at all, so a write can never reach the host
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         cfg_rdata <= ppm_pkg::PPM_ZERO; // cleared; the straps themselves never reset
      end
      else if (cfg_rd)
      begin
         cfg_rdata <= next_rdata; // held until the next read
      end
   end

   // ****************************************
   // checks
   // ****************************************
   // every check below looks one edge after the strobe, which is where
   // cfg_rdata and cfg_rvalid first show the answer; the field checks
   // use literal values so that a wrong package constant is caught too
   // a read that hits this dword
   sequence s_hit_read;
      cfg_rd && cfg_hit;
   endsequence

   // wake field follows the aux supply level at the strobe edge
   property p_wake_aux;
      @(posedge core_clk) disable iff (srst)
      s_hit_read and aux_present |=> cfg_rvalid && cfg_rdata[31:27] == 5'h1f;
   endproperty
   a_wake_aux: assert property (p_wake_aux) else $error("wake field wrong with aux");

   property p_wake_noaux;
      @(posedge core_clk) disable iff (srst)
      s_hit_read and !aux_present |=> cfg_rdata[31:27] == 5'h0f;
   endproperty
   a_wake_noaux: assert property (p_wake_noaux) else $error("wake field wrong without aux");

   property p_dstates;
      @(posedge core_clk) disable iff (srst)
      s_hit_read |=> cfg_rdata[26:25] == 2'h3;
   endproperty
   a_dstates: assert property (p_dstates) else $error("d1/d2 support not set");

   property p_version;
      @(posedge core_clk) disable iff (srst)
      s_hit_read and autoload_en |=> cfg_rdata[18:16] == 3'h2;
   endproperty
   a_version: assert property (p_version) else $error("version not 1.0a");

   // the older layout zeroes the aux field and reports version 001b
   property p_layout10;
      @(posedge core_clk) disable iff (srst)
      s_hit_read and !autoload_en |=> cfg_rdata[18:16] == 3'h1 && cfg_rdata[24:22] == 3'h0;
   endproperty
   a_layout10: assert property (p_layout10) else $error("1.0 layout wrong");

   // the aux field follows the strap value seen at the strobe edge
   property p_aux;
      @(posedge core_clk) disable iff (srst)
      s_hit_read and autoload_en |=> cfg_rdata[24:22] == $past(aux_current_requirement);
   endproperty
   a_aux: assert property (p_aux) else $error("aux current not reported");

   property p_zero_bits;
      @(posedge core_clk) disable iff (srst)
      s_hit_read |=> cfg_rdata[21:19] == 3'h0;
   endproperty
   a_zero_bits: assert property (p_zero_bits) else $error("bits 21..19 not zero");

   property p_next;
      @(posedge core_clk) disable iff (srst)
      s_hit_read |=> cfg_rdata[15:8] == 8'h00;
   endproperty
   a_next: assert property (p_next) else $error("next pointer not zero");

   property p_id;
      @(posedge core_clk) disable iff (srst)
      s_hit_read |=> cfg_rdata[7:0] == 8'h01;
   endproperty
   a_id: assert property (p_id) else $error("capability id wrong");

   // a lone write strobe must leave the last read value in place
   property p_write_ignored;
      @(posedge core_clk) disable iff (srst)
      cfg_wr && !cfg_rd |=> $stable(cfg_rdata);
   endproperty
   a_write_ignored: assert property (p_write_ignored) else $error("write changed read data");

   // ****************************************
   // read timing checks
   // ****************************************
   // a strobe that lands while reset is sampled high gets no answer,
   // so the quiet-cycle checks also require reset to be low; this keeps
   // the clearing edge of a mid-run reset from looking like a stray load
   // of the read data register
   sequence s_quiet;
      !cfg_rd && !srst;
   endsequence

   property p_answer;
      @(posedge core_clk) disable iff (srst)
      cfg_rd |=> cfg_rvalid;
   endproperty
   a_answer: assert property (p_answer) else $error("read strobe not answered");

   property p_no_answer;
      @(posedge core_clk) disable iff (srst)
      s_quiet |=> !cfg_rvalid;
   endproperty
   a_no_answer: assert property (p_no_answer) else $error("valid without a read strobe");

   property p_hold;
      @(posedge core_clk) disable iff (srst)
      s_quiet |=> $stable(cfg_rdata);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved without a read");

   property p_miss;
      @(posedge core_clk) disable iff (srst)
      cfg_rd && !cfg_hit |=> cfg_rdata == 32'h0000_0000;
   endproperty
   a_miss: assert property (p_miss) else $error("miss did not read zero");

   // reset is a level; the check must not be switched off by it
   property p_reset_clears;
      @(posedge core_clk)
      srst |=> !cfg_rvalid && cfg_rdata == 32'h0000_0000;
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("reset left read port busy");
endmodule

// file: test/ppm_host_model.sv
// Purpose: host model issuing configuration cycles
// Assumes: bench raises requests just after clock edges
// Notes:   idle address and data lines show inverted values
`timescale 1ns/100ps
module ppm_host_model
(
   input  wire logic        core_clk,   // bus clock
   input  wire logic        rd_req,     // bench read request
   input  wire logic        wr_req,     // bench write request
   input  wire logic [7:0]  req_addr,   // request offset
   input  wire logic [31:0] req_wdata,  // request data
   input  wire logic [31:0] cfg_rdata,  // device read data
   input  wire logic        cfg_rvalid, // device data valid
   output logic             cfg_rd,     // read strobe
   output logic             cfg_wr,     // write strobe
   output logic      [7:0]  cfg_addr,   // driven offset
   output logic      [31:0] cfg_wdata,  // driven data
   output logic      [31:0] seen_data   // captured read data
);
   // idle lines never echo the last value
   assign cfg_rd    = rd_req;
   assign cfg_wr    = wr_req;
   assign cfg_addr  = (rd_req | wr_req) ? req_addr : ~req_addr;
   assign cfg_wdata = wr_req ? req_wdata : ~req_wdata;
   // capture data on the valid pulse
   always_ff @(posedge core_clk)
   begin
      if (cfg_rvalid)
      begin
         seen_data <= cfg_rdata;
      end
   end
endmodule

// file: test/pci_pm_capability_regs_tb_top.sv
// Purpose: random and corner reads of the capability dword
// Assumes: read data one cycle after the strobe
// Notes:   writes precede reads back to back
`timescale 1ns/100ps
module pci_pm_capability_regs_tb_top;
   logic        core_clk, srst, rd_req, wr_req, aux_present, autoload_en, cfg_rd, cfg_wr, cfg_rvalid, cfg_hit;
   logic [7:0]  req_addr, cfg_addr; // offsets
   logic [2:0]  aux_cur;            // strapped current
   logic [31:0] req_wdata, cfg_wdata, cfg_rdata, seen_data, exp;
   integer      error_cnt, compares, seed, cycles, i;
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] exp_val(input logic aux, input logic al, input logic [2:0] c, input logic [7:0] a);
      logic [4:0] w;
      w = aux ? 5'h1f : 5'h0f;
      if (a !== 8'h40) return 32'h0000_0000;
      return al ? {w, 2'h3, c, 3'h0, 3'h2, 16'h0001} : {w, 2'h3, 3'h0, 3'h0, 3'h1, 16'h0001};
   endfunction
   task chk(input logic [31:0] seen, input logic [31:0] want);
      compares = compares + 1;
      if (seen !== want)
      begin
         error_cnt = error_cnt + 1;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask
   task give_verdict;
      if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // one read: strobe, answer next cycle, host capture after
   task rd(input logic [7:0] a);
      @(posedge core_clk);
      wr_req <= 1'b0;
      rd_req <= 1'b1;
      req_addr <= a;
      #1 exp = exp_val(aux_present, autoload_en, aux_cur, a);
      chk(cfg_hit, a == 8'h40);
      @(posedge core_clk);
      rd_req <= 1'b0;
      #1 chk(cfg_rvalid, 1'b1);
      chk(cfg_rdata, exp);
      chk(cfg_rdata[31:27], exp[31:27]);
      chk(cfg_rdata[26:25], exp[26:25]);
      chk(cfg_rdata[24:22], exp[24:22]);
      chk(cfg_rdata[21:19], exp[21:19]);
      chk(cfg_rdata[18:16], exp[18:16]);
      chk(cfg_rdata[15:0], exp[15:0]);
      @(posedge core_clk);
      #1 chk(cfg_rvalid, 1'b0);
      chk(seen_data, exp);
   endtask
   // ****************************************
   // clock, timeout, design
   // ****************************************
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   initial cycles = 0;
   always @(posedge core_clk)
   begin
      cycles = cycles + 1;
      if (cycles == 2000)
      begin
         error_cnt = error_cnt + 1;
         give_verdict;
      end
   end
   ppm_host_model host_u (.core_clk(core_clk), .rd_req(rd_req), .wr_req(wr_req), .req_addr(req_addr),
      .req_wdata(req_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .seen_data(seen_data));
   ppm_cap_regs dut_u (.core_clk(core_clk), .srst(srst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata), .aux_present(aux_present), .autoload_en(autoload_en),
      .aux_current_requirement(aux_cur), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .cfg_hit(cfg_hit));
   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      seed = 32'hc5c9;
      error_cnt = 0;
      compares = 0;
      {srst, rd_req, wr_req, aux_present, autoload_en, aux_cur, req_addr, req_wdata} = {1'b1, 47'h0};
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      // first eight passes walk every strap corner, then random
      for (i = 0; i < 48; i++)
      begin
         @(posedge core_clk);
         aux_present <= (i < 8) ? i[0] : 1'($random(seed));
         autoload_en <= (i < 8) ? i[1] : 1'($random(seed));
         aux_cur <= (i < 8) ? {3{i[2]}} : 3'($random(seed));
         wr_req <= i[0] | (i > 7);
         req_addr <= 8'h40;
         req_wdata <= $random(seed);
         rd((i % 5 == 4) ? 8'($random(seed)) : 8'h40);
      end
      // reset in mid-run leaves the straps readable
      @(posedge core_clk);
      srst <= 1'b1;
      @(posedge core_clk);
      srst <= 1'b0;
      #1 chk(cfg_rvalid, 1'b0);
      chk(cfg_rdata, 32'h0000_0000);
      rd(8'h40);
      give_verdict;
   end
endmodule
